// ---- verilog/scu_defs.vh ----
// Constants for the serial communication unit control and status block
`ifndef SCU_DEFS_VH
`define SCU_DEFS_VH
`define SCU_MODE_W 2
`define SCU_MODE_UART 2'h0
`define SCU_MODE_SPI 2'h1
`define SCU_MODE_I2C 2'h2
`define SCU_DBG_W 8
`define SCU_DBG_RST 8'h00
`define SCU_CFG_W 8
`define SCU_CFG_RST 8'h00
`define SCU_CFG_RUNSTBY 0
`define SCU_CFG_RECEIVER_ENABLE 1
`define SCU_CFG_AACK 2
`define SCU_RST_CYC_NS 50
`define SCU_CLK_NS 50
`define SCU_SOFT_RESET_REQUEST_CYC ((`SCU_RST_CYC_NS + `SCU_CLK_NS - 1) / `SCU_CLK_NS)
`endif

// ---- verilog/scu_i2c_client.v ----
// I2C client event tracking: address match, first data-ready, nack validity
`timescale 1ns/1ns
`include "scu_defs.vh"
module scu_i2c_client (
  input wire ref_clk,
  input wire clr,
  input wire auto_acknowledge_enable,
  input wire addr_match_ev,
  input wire rep_start_ev,
  input wire data_ready_ev,
  input wire nack_ev,
  output reg auto_ack_q,
  output reg first_data_ready_interrupt_q,
  output reg nack_valid_q
);
  reg seen_data_ready_interrupt_q;
  always @(posedge ref_clk) begin
    if (clr) begin
      auto_ack_q <= 1'b0;
      first_data_ready_interrupt_q <= 1'b0;
      nack_valid_q <= 1'b0;
      seen_data_ready_interrupt_q <= 1'b0;
    end else begin
      // RULE6 no auto ack on repeated start
      auto_ack_q <= addr_match_ev & auto_acknowledge_enable & ~rep_start_ev;
      // RULE7 first data_ready_interrupt marks nack invalid
      if (addr_match_ev) begin
        seen_data_ready_interrupt_q <= 1'b0;
        first_data_ready_interrupt_q <= 1'b0;
        nack_valid_q <= 1'b0;
      end else if (data_ready_ev) begin
        seen_data_ready_interrupt_q <= 1'b1;
        first_data_ready_interrupt_q <= ~seen_data_ready_interrupt_q;
        nack_valid_q <= seen_data_ready_interrupt_q & nack_ev;
      end else begin
        first_data_ready_interrupt_q <= 1'b0;
      end
    end
  end
endmodule // scu_i2c_client

// ---- verilog/scu_core.v ----
// Serial communication unit control, standby request and wake logic
// Notes on behaviour
// RULE1: UART, no run-in-standby, receiver off: clock request stays on in standby.
// RULE2: UART error flag never wakes; only receive complete wakes.
// RULE3: Soft reset request ignored while the unit is disabled.
// RULE4: Unexpected STOP sets bus and error flags but does not wake.
// RULE5: Soft reset also returns debug halt control to reset value.
// RULE6: I2C client auto acknowledge withheld on repeated start.
// RULE7: Received nack invalid at first data ready; cleared on address match.
// RULE8: Enabled soft reset restores all registers and clears enable.
`timescale 1ns/1ns
`include "scu_defs.vh"
module scu_core (
  input wire ref_clk,
  input wire sys_rst,
  input wire enable_set,
  input wire soft_reset_request,
  input wire [`SCU_MODE_W-1:0] mode_in,
  input wire [`SCU_CFG_W-1:0] cfg_wr_data,
  input wire cfg_wr,
  input wire [`SCU_DBG_W-1:0] dbg_wr_data,
  input wire dbg_wr,
  input wire standby,
  input wire uart_error_ev,
  input wire receive_complete_interrupt,
  input wire parity_ev,
  input wire framing_ev,
  input wire unexp_stop_ev,
  input wire unexp_start_ev,
  input wire flag_clr,
  input wire addr_match_ev,
  input wire rep_start_ev,
  input wire data_ready_ev,
  input wire nack_ev,
  output reg enable_q,
  output reg [`SCU_MODE_W-1:0] mode_q,
  output reg [`SCU_CFG_W-1:0] cfg_q,
  output reg [`SCU_DBG_W-1:0] debug_halt_control_q,
  output reg clk_req_q,
  output reg wake_q,
  output reg fault_irq_flag_q,
  output reg bus_fault_flag_q,
  output reg parity_fault_flag_q,
  output reg framing_fault_flag_q,
  output reg auto_ack_q,
  output reg first_data_ready_interrupt_q,
  output reg received_nack_flag_q
);
  // Next values of the configuration registers
  reg enable_d;
  reg [`SCU_MODE_W-1:0] mode_d;
  reg [`SCU_CFG_W-1:0] cfg_d;
  reg [`SCU_DBG_W-1:0] dbg_d;
  // Next values of the power and flag outputs
  reg clk_req_d;
  reg wake_d;
  reg fault_irq_d;
  reg bus_fault_d;
  reg parity_fault_d;
  reg framing_fault_d;
  // Decoded state and gated events
  wire soft_reset_request_act;
  wire is_uart;
  wire is_i2c;
  wire uart_live;
  wire i2c_live;
  wire uart_err_hit;
  wire stop_hit;
  wire start_hit;
  wire rx_done_hit;
  wire i2c_clr;
  // Client tracker outputs, one stage before the ports
  wire auto_ack_d;
  wire first_data_ready_interrupt_d;
  wire nack_d;

  // Mode decode shared by request, wake and flag logic
  function mode_is;
    input [`SCU_MODE_W-1:0] cur;
    input [`SCU_MODE_W-1:0] want;
    begin
      mode_is = (cur == want);
    end
  endfunction

  // Sticky flag: a set in the clear cycle wins, so no event is lost
  function sticky_next;
    input cur;
    input clr;
    input set;
    begin
      sticky_next = (cur & ~clr) | set;
    end
  endfunction

  // RULE3 reset only when enabled
  assign soft_reset_request_act = soft_reset_request & enable_q;
  assign is_uart = mode_is(mode_q, `SCU_MODE_UART);
  assign is_i2c = mode_is(mode_q, `SCU_MODE_I2C);
  // Line events count only while the unit is enabled
  assign uart_live = enable_q & is_uart;
  assign i2c_live = enable_q & is_i2c;
  assign uart_err_hit = uart_live & uart_error_ev;
  assign stop_hit = i2c_live & unexp_stop_ev;
  assign start_hit = i2c_live & unexp_start_ev;
  assign rx_done_hit = uart_live & receive_complete_interrupt;
  // Tracker restarts on any reset, when disabled or out of I2C mode
  assign i2c_clr = sys_rst | soft_reset_request_act | ~i2c_live;

  scu_i2c_client u_i2c (
    .ref_clk(ref_clk),
    .clr(i2c_clr),
    .auto_acknowledge_enable(cfg_q[`SCU_CFG_AACK]),
    .addr_match_ev(addr_match_ev),
    .rep_start_ev(rep_start_ev),
    .data_ready_ev(data_ready_ev),
    .nack_ev(nack_ev),
    .auto_ack_q(auto_ack_d),
    .first_data_ready_interrupt_q(first_data_ready_interrupt_d),
    .nack_valid_q(nack_d)
  );

  // Configuration registers; mode and config move only while disabled
  always @* begin
    enable_d = enable_q;
    mode_d = mode_q;
    cfg_d = cfg_q;
    dbg_d = debug_halt_control_q;
    if (enable_set) begin
      enable_d = 1'b1;
    end
    if (!enable_q) begin
      mode_d = mode_in;
      if (cfg_wr) begin
        cfg_d = cfg_wr_data;
      end
    end
    // Debug control stays writable while the unit runs
    if (dbg_wr) begin
      dbg_d = dbg_wr_data;
    end
  end

  // Clock request and wake pulse
  always @* begin
    // RULE1 request held in standby
    // Costs power: the request stays up with nothing to receive
    clk_req_d = enable_q & (~standby | cfg_q[`SCU_CFG_RUNSTBY] |
      (is_uart & ~cfg_q[`SCU_CFG_RECEIVER_ENABLE]));
    // RULE2 in UART mode only receive complete wakes
    // RULE4 unexpected STOP does not wake, START does
    wake_d = standby & (rx_done_hit | start_hit);
  end

  // Error flags
  always @* begin
    // RULE2 error flag set, no wake
    fault_irq_d = sticky_next(fault_irq_flag_q, flag_clr,
      uart_err_hit | stop_hit);
    // RULE4 unexpected STOP raises both flags
    bus_fault_d = sticky_next(bus_fault_flag_q, flag_clr, stop_hit);
    parity_fault_d = sticky_next(parity_fault_flag_q, flag_clr,
      uart_live & parity_ev);
    framing_fault_d = sticky_next(framing_fault_flag_q, flag_clr,
      uart_live & framing_ev);
  end

  // Configuration and debug registers
  always @(posedge ref_clk) begin
    if (sys_rst || soft_reset_request_act) begin
      // RULE8 registers back to reset values
      enable_q <= 1'b0;
      mode_q <= `SCU_MODE_UART;
      cfg_q <= `SCU_CFG_RST;
      // RULE5 debug control lost too
      debug_halt_control_q <= `SCU_DBG_RST;
    end else begin
      enable_q <= enable_d;
      mode_q <= mode_d;
      cfg_q <= cfg_d;
      debug_halt_control_q <= dbg_d;
    end
  end

  // Power management outputs
  always @(posedge ref_clk) begin
    if (sys_rst || soft_reset_request_act) begin
      clk_req_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      clk_req_q <= clk_req_d;
      wake_q <= wake_d;
    end
  end

  // Sticky error flags
  always @(posedge ref_clk) begin
    if (sys_rst || soft_reset_request_act) begin
      fault_irq_flag_q <= 1'b0;
      bus_fault_flag_q <= 1'b0;
      parity_fault_flag_q <= 1'b0;
      framing_fault_flag_q <= 1'b0;
    end else begin
      fault_irq_flag_q <= fault_irq_d;
      bus_fault_flag_q <= bus_fault_d;
      parity_fault_flag_q <= parity_fault_d;
      framing_fault_flag_q <= framing_fault_d;
    end
  end

  // I2C client pulses, registered again so every port leaves a flop here
  always @(posedge ref_clk) begin
    if (sys_rst || soft_reset_request_act) begin
      auto_ack_q <= 1'b0;
      first_data_ready_interrupt_q <= 1'b0;
      received_nack_flag_q <= 1'b0;
    end else begin
      // RULE6 auto ack pulse passed out
      auto_ack_q <= auto_ack_d;
      // RULE7 nack flag only when valid
      first_data_ready_interrupt_q <= first_data_ready_interrupt_d;
      received_nack_flag_q <= nack_d;
    end
  end
endmodule // scu_core

// ---- test/scu_peer.sv ----
// Serial bus peer: line events, each one clock long
`timescale 1ns/1ns
module scu_peer (
  input wire ref_clk,
  output reg [9:0] ev_q
);
  initial ev_q = 10'h000;
  task send(input [9:0] m);
    begin
      @(negedge ref_clk) ev_q = m;
      @(negedge ref_clk) ev_q = 10'h000;
    end
  endtask
endmodule // scu_peer

// ---- test/scu_core_checker.sv ----
// Port checker for the serial unit control block
`timescale 1ns/1ns
`include "scu_defs.vh"
module scu_chk (
  input wire ref_clk,
  input wire sys_rst,
  input wire soft_reset_request,
  input wire dbg_wr,
  input wire standby,
  input wire receive_complete_interrupt,
  input wire unexp_stop_ev,
  input wire unexp_start_ev,
  input wire rep_start_ev,
  input wire enable_q,
  input wire clk_req_q,
  input wire wake_q,
  input wire fault_irq_flag_q,
  input wire bus_fault_flag_q,
  input wire auto_ack_q,
  input wire first_data_ready_interrupt_q,
  input wire received_nack_flag_q,
  input wire [`SCU_MODE_W-1:0] mode_q,
  input wire [`SCU_CFG_W-1:0] cfg_q,
  input wire [`SCU_DBG_W-1:0] debug_halt_control_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Soft reset acts whenever it is asked for while enabled
  wire srst = enable_q & soft_reset_request;
  stby_req_a: assert property (enable_q && mode_q == `SCU_MODE_UART
    && standby && cfg_q[1:0] == 2'h0 && !srst |=> clk_req_q) else $error("req");
  no_wake_a: assert property (!receive_complete_interrupt
    && !unexp_start_ev |=> !wake_q) else $error("wake");
  off_srst_a: assert property (soft_reset_request && !enable_q
    && !dbg_wr |=> $stable(debug_halt_control_q)) else $error("srst off");
  stop_flag_a: assert property (enable_q && unexp_stop_ev && !srst
    && mode_q == `SCU_MODE_I2C |=> bus_fault_flag_q && fault_irq_flag_q)
    else $error("stop");
  srst_dbg_a: assert property (srst
    |=> debug_halt_control_q == `SCU_DBG_RST) else $error("dbg");
  rep_ack_a: assert property ($past(rep_start_ev, 2)
    |-> !auto_ack_q) else $error("ack");
  nack_first_a: assert property (first_data_ready_interrupt_q
    |-> !received_nack_flag_q) else $error("nack");
  srst_all_a: assert property (srst
    |=> !enable_q && cfg_q == `SCU_CFG_RST) else $error("srst");
  cover property (clk_req_q);
  cover property (auto_ack_q);
  cover property (first_data_ready_interrupt_q);
  cover property (wake_q);
endmodule // scu_chk
bind scu_core scu_chk u_chk (
  .ref_clk(ref_clk),
  .sys_rst(sys_rst),
  .soft_reset_request(soft_reset_request),
  .dbg_wr(dbg_wr),
  .standby(standby),
  .receive_complete_interrupt(receive_complete_interrupt),
  .unexp_stop_ev(unexp_stop_ev),
  .unexp_start_ev(unexp_start_ev),
  .rep_start_ev(rep_start_ev),
  .enable_q(enable_q),
  .clk_req_q(clk_req_q),
  .wake_q(wake_q),
  .fault_irq_flag_q(fault_irq_flag_q),
  .bus_fault_flag_q(bus_fault_flag_q),
  .auto_ack_q(auto_ack_q),
  .first_data_ready_interrupt_q(first_data_ready_interrupt_q),
  .received_nack_flag_q(received_nack_flag_q),
  .mode_q(mode_q),
  .cfg_q(cfg_q),
  .debug_halt_control_q(debug_halt_control_q)
);

// ---- test/scu_core_tb.sv ----
// Self-checking bench for the serial unit control block
`timescale 1ns/1ns
module scu_core_tb;
  reg ref_clk = 0, sys_rst = 1, enable_set = 0, soft_reset_request = 0;
  reg cfg_wr = 0, dbg_wr = 0, standby = 0, flag_clr = 0;
  reg [1:0] mode_in = 0;
  reg [7:0] cfg_wr_data = 0, dbg_wr_data = 0;
  wire [9:0] ev;
  wire enable_q, clk_req_q, wake_q, fault_irq_flag_q, bus_fault_flag_q;
  wire parity_fault_flag_q, framing_fault_flag_q, auto_ack_q;
  wire first_data_ready_interrupt_q, received_nack_flag_q;
  wire [1:0] mode_q;
  wire [7:0] cfg_q, debug_halt_control_q;
  integer num_errors = 0, samples_checked = 0, cycles = 0;
  scu_peer peer (.ref_clk(ref_clk), .ev_q(ev));
  scu_core dut (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .enable_set(enable_set),
    .soft_reset_request(soft_reset_request),
    .mode_in(mode_in),
    .cfg_wr_data(cfg_wr_data),
    .cfg_wr(cfg_wr),
    .dbg_wr_data(dbg_wr_data),
    .dbg_wr(dbg_wr),
    .standby(standby),
    .uart_error_ev(ev[0]),
    .receive_complete_interrupt(ev[1]),
    .parity_ev(ev[2]),
    .framing_ev(ev[3]),
    .unexp_stop_ev(ev[4]),
    .unexp_start_ev(ev[5]),
    .flag_clr(flag_clr),
    .addr_match_ev(ev[6]),
    .rep_start_ev(ev[7]),
    .data_ready_ev(ev[8]),
    .nack_ev(ev[9]),
    .enable_q(enable_q),
    .mode_q(mode_q),
    .cfg_q(cfg_q),
    .debug_halt_control_q(debug_halt_control_q),
    .clk_req_q(clk_req_q),
    .wake_q(wake_q),
    .fault_irq_flag_q(fault_irq_flag_q),
    .bus_fault_flag_q(bus_fault_flag_q),
    .parity_fault_flag_q(parity_fault_flag_q),
    .framing_fault_flag_q(framing_fault_flag_q),
    .auto_ack_q(auto_ack_q),
    .first_data_ready_interrupt_q(first_data_ready_interrupt_q),
    .received_nack_flag_q(received_nack_flag_q)
  );
  always #25 ref_clk = ~ref_clk;
  task ck(input [63:0] n, input [7:0] e, g);
    begin
      samples_checked++;
      if (g !== e) begin
        num_errors++;
        $display("ERROR %0s exp %h got %h", n, e, g);
      end
    end
  endtask
  task tick;
    @(negedge ref_clk);
  endtask
  task test_done;
    begin
      if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Whole run needs about 38 cycles
  always @(posedge ref_clk) if (++cycles > 200) begin
    num_errors++;
    test_done;
  end
  initial begin
    repeat (5) tick;
    sys_rst = 0;
    dbg_wr = 1;
    dbg_wr_data = 8'h5A;
    tick;
    dbg_wr = 0;
    soft_reset_request = 1;
    tick;
    ck("dbg", 8'h5A, debug_halt_control_q);
    soft_reset_request = 0;
    // Unused upper bits make the later reset of the config visible
    cfg_wr_data = 8'hF0;
    cfg_wr = 1;
    tick;
    cfg_wr = 0;
    enable_set = 1;
    standby = 1;
    tick;
    enable_set = 0;
    tick;
    ck("clkreq", 8'h01, clk_req_q);
    peer.send(10'h001);
    ck("wake", 8'h00, wake_q);
    ck("err", 8'h01, fault_irq_flag_q);
    peer.send(10'h00C);
    ck("wake", 8'h00, wake_q);
    ck("parity", 8'h01, parity_fault_flag_q);
    ck("framing", 8'h01, framing_fault_flag_q);
    peer.send(10'h002);
    ck("wake", 8'h01, wake_q);
    // Clear held over two edges; the second one meets a new parity error
    flag_clr = 1;
    peer.send(10'h004);
    flag_clr = 0;
    ck("parity", 8'h01, parity_fault_flag_q);
    ck("framing", 8'h00, framing_fault_flag_q);
    ck("err", 8'h00, fault_irq_flag_q);
    soft_reset_request = 1;
    tick;
    soft_reset_request = 0;
    ck("dbg", 8'h00, debug_halt_control_q);
    ck("en", 8'h00, enable_q);
    ck("cfg", 8'h00, cfg_q);
    ck("parity", 8'h00, parity_fault_flag_q);
    mode_in = 2;
    cfg_wr_data = 8'h04;
    cfg_wr = 1;
    tick;
    cfg_wr = 0;
    enable_set = 1;
    tick;
    enable_set = 0;
    peer.send(10'h010);
    ck("bus", 8'h01, bus_fault_flag_q);
    ck("err", 8'h01, fault_irq_flag_q);
    ck("wake", 8'h00, wake_q);
    ck("mode", 8'h02, mode_q);
    ck("clkreq", 8'h00, clk_req_q);
    peer.send(10'h020);
    ck("wake", 8'h01, wake_q);
    standby = 0;
    tick;
    ck("clkreq", 8'h01, clk_req_q);
    peer.send(10'h0C0);
    tick;
    ck("ack", 8'h00, auto_ack_q);
    peer.send(10'h040);
    tick;
    ck("ack", 8'h01, auto_ack_q);
    peer.send(10'h300);
    tick;
    ck("first", 8'h01, first_data_ready_interrupt_q);
    ck("nack", 8'h00, received_nack_flag_q);
    peer.send(10'h300);
    tick;
    ck("first", 8'h00, first_data_ready_interrupt_q);
    ck("nack", 8'h01, received_nack_flag_q);
    test_done;
  end
endmodule // scu_core_tb
